// ---- logic/ttx_pkg.sv ----
// Behaviour
// RQ1 - timer 4 takes both nibbles of the timer 4 low reload register
// RQ2 - accumulator takes register B; register B keeps its value
// RQ3 - read timer 1: B gets bits 7..4, accumulator bits 3..0, one cycle
// RQ4 - read timer 2: B gets bits 7..4, accumulator bits 3..0, one cycle
// RQ5 - load: B to upper, accumulator to lower nibble of timer 4 and reload
// RQ6 - one word, one cycle, carry untouched, next instruction never skipped
package ttx_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int unsigned INSTR_W = 10;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned TMR_W = 8;

  // ------------------------------------------------------------
  // instruction encodings
  // ------------------------------------------------------------
  localparam logic [INSTR_W-1:0] OP_LOAD_T4_FROM_RELOAD = 10'h297;
  localparam logic [INSTR_W-1:0] OP_MOVE_B_TO_ACC = 10'h01e;
  localparam logic [INSTR_W-1:0] OP_READ_T1 = 10'h270;
  localparam logic [INSTR_W-1:0] OP_READ_T2 = 10'h271;
  localparam logic [INSTR_W-1:0] OP_LOAD_T4_AND_RELOAD = 10'h233;

  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic [NIB_W-1:0] ACC_RST = 4'h0;
  localparam logic [NIB_W-1:0] B_RST = 4'h0;
  localparam logic [TMR_W-1:0] TMR4_RST = 8'h00;
  localparam logic [TMR_W-1:0] RELOAD4_RST = 8'h00;
  localparam int unsigned EXEC_CYCLES = 1;

  // decoded operation, one-hot
  typedef enum logic [5:0] {
    TTX_OP_NONE = 6'b000001,
    TTX_OP_T4_FROM_RELOAD = 6'b000010,
    TTX_OP_B_TO_ACC = 6'b000100,
    TTX_OP_READ_T1 = 6'b001000,
    TTX_OP_READ_T2 = 6'b010000,
    TTX_OP_T4_AND_RELOAD = 6'b100000
  } ttx_op_t;
endpackage

// ---- logic/ttx_dec_if.sv ----
`timescale 1ns/10ps
// carries the fetched word to the decoder and the decoded operation back
interface ttx_dec_if;
  import ttx_pkg::*;
  logic [INSTR_W-1:0] word;
  logic valid;
  ttx_op_t op;
  modport dec (input word, input valid, output op);
  modport exe (output word, output valid, input op);
endinterface

// ---- logic/ttx_decoder.sv ----
`timescale 1ns/10ps
module ttx_decoder (
  ttx_dec_if.dec d // word in, operation out
);
  import ttx_pkg::*;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // words outside this group decode to none so neighbours own them
  always_comb begin
    d.op = TTX_OP_NONE;
    if (d.valid) begin
      case (d.word)
        OP_LOAD_T4_FROM_RELOAD: d.op = TTX_OP_T4_FROM_RELOAD;
        OP_MOVE_B_TO_ACC: d.op = TTX_OP_B_TO_ACC;
        OP_READ_T1: d.op = TTX_OP_READ_T1;
        OP_READ_T2: d.op = TTX_OP_READ_T2;
        OP_LOAD_T4_AND_RELOAD: d.op = TTX_OP_T4_AND_RELOAD;
        default: d.op = TTX_OP_NONE;
      endcase
    end
  end
endmodule

// ---- logic/ttx_exec.sv ----
`timescale 1ns/10ps
module ttx_exec (
  input wire logic sys_clk, // instruction clock
  input wire logic rst, // synchronous, active high
  input wire logic instr_valid, // one-cycle pulse, word is fetched
  input wire logic [ttx_pkg::INSTR_W-1:0] instr_word, // fetched word
  input wire logic [ttx_pkg::TMR_W-1:0] timer1, // running timer 1 count
  input wire logic [ttx_pkg::TMR_W-1:0] timer2, // running timer 2 count
  output logic [ttx_pkg::NIB_W-1:0] acc, // accumulator
  output logic [ttx_pkg::NIB_W-1:0] reg_b, // register B
  output logic [ttx_pkg::TMR_W-1:0] timer4, // timer 4 load value
  output logic timer4_load, // pulse: timer 4 loaded
  output logic [ttx_pkg::TMR_W-1:0] timer4_low_reload_reg, // reload source
  output logic instr_done, // pulse: a group instruction retired
  output logic skip_next // skip request, never set here
);
  import ttx_pkg::*;

  // the decoder is purely combinational, so decode and execute share one edge
  ttx_dec_if dif ();

  assign dif.word = instr_word;
  assign dif.valid = instr_valid;

  ttx_decoder u_dec (
    .d(dif)
  );

  // ------------------------------------------------------------
  // accumulator and register B
  // ------------------------------------------------------------
  // timers are sampled in the same cycle, so a nibble pair never tears
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc <= ACC_RST;
      reg_b <= B_RST;
    end else begin
      case (dif.op)
        TTX_OP_B_TO_ACC: acc <= reg_b; // RQ2
        TTX_OP_READ_T1: begin
          reg_b <= timer1[7:4]; // RQ3
          acc <= timer1[3:0]; // RQ3
        end
        TTX_OP_READ_T2: begin
          reg_b <= timer2[7:4]; // RQ4
          acc <= timer2[3:0]; // RQ4
        end
        default: acc <= acc;
      endcase
    end
  end

  // ------------------------------------------------------------
  // timer 4 and its low reload register
  // ------------------------------------------------------------
  // the load pulse tells the counter to take timer4; the reload copy reads the
  // register before the edge, so a load followed at once by a copy sees the new value
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer4 <= TMR4_RST;
      timer4_low_reload_reg <= RELOAD4_RST;
      timer4_load <= 1'b0;
    end else begin
      timer4_load <= 1'b0;
      case (dif.op)
        TTX_OP_T4_FROM_RELOAD: begin
          timer4 <= timer4_low_reload_reg; // RQ1
          timer4_load <= 1'b1;
        end
        TTX_OP_T4_AND_RELOAD: begin
          timer4 <= {reg_b, acc}; // RQ5
          timer4_low_reload_reg <= {reg_b, acc}; // RQ5
          timer4_load <= 1'b1;
        end
        default: timer4 <= timer4;
      endcase
    end
  end

  // ------------------------------------------------------------
  // retire
  // ------------------------------------------------------------
  // carry is not an input here at all, so none of these can touch it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      instr_done <= 1'b0;
      skip_next <= 1'b0;
    end else begin
      instr_done <= (dif.op != TTX_OP_NONE); // RQ6
      skip_next <= 1'b0; // RQ6
    end
  end

  // ------------------------------------------------------------
  // check helpers
  // ------------------------------------------------------------
  // the checks decode the raw word themselves, so a slip in the decoder
  // cannot hide behind its own output
  logic hit_t4_from_reload;
  logic hit_b_to_acc;
  logic hit_read_t1;
  logic hit_read_t2;
  logic hit_t4_and_reload;
  logic hit_read;
  logic hit_timer4;
  logic hit_any;

  // raw word matches, qualified by the valid strobe
  assign hit_t4_from_reload = instr_valid && (instr_word == OP_LOAD_T4_FROM_RELOAD);
  assign hit_b_to_acc = instr_valid && (instr_word == OP_MOVE_B_TO_ACC);
  assign hit_read_t1 = instr_valid && (instr_word == OP_READ_T1);
  assign hit_read_t2 = instr_valid && (instr_word == OP_READ_T2);
  assign hit_t4_and_reload = instr_valid && (instr_word == OP_LOAD_T4_AND_RELOAD);

  // groupings by what each instruction is allowed to write
  assign hit_read = hit_read_t1 || hit_read_t2;
  assign hit_timer4 = hit_t4_from_reload || hit_t4_and_reload;
  assign hit_any = hit_read || hit_timer4 || hit_b_to_acc;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // all checks are quiet while reset is high; the source checks also forgive
  // the first edge after it, where reset values show up as a change
  // the copy takes the reload register as it stood before the edge
  reload_copy_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
    (instr_valid && instr_word == OP_LOAD_T4_FROM_RELOAD)
      |=> (timer4 == $past(timer4_low_reload_reg)) && timer4_load)
    else $error("timer 4 not loaded from reload register");

  // the move reads B and leaves it as it was
  b_to_acc_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
    (instr_valid && instr_word == OP_MOVE_B_TO_ACC)
      |=> (acc == $past(reg_b)) && $stable(reg_b))
    else $error("accumulator did not take register B");

  // both nibbles of timer 1 come from one sample
  read_t1_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ3
    (instr_valid && instr_word == OP_READ_T1)
      |=> ({reg_b, acc} == $past(timer1)) && instr_done)
    else $error("timer 1 read wrong");

  // both nibbles of timer 2 come from one sample
  read_t2_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ4
    (instr_valid && instr_word == OP_READ_T2)
      |=> ({reg_b, acc} == $past(timer2)) && instr_done)
    else $error("timer 2 read wrong");

  // a copy right after a load must carry the value that the load wrote
  load_pair_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ5
    (instr_valid && instr_word == OP_LOAD_T4_AND_RELOAD) ##1
      (instr_valid && instr_word == OP_LOAD_T4_FROM_RELOAD)
      |=> timer4 == {$past(reg_b, 2), $past(acc, 2)})
    else $error("reload did not carry the freshly loaded value");

  // retire pulses last one cycle unless another word follows at once
  one_cycle_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
    instr_done |-> !skip_next ##1 (!instr_done || $past(instr_valid)))
    else $error("group instruction took more than one cycle or skipped");

  // both halves of the load land together, with the values before the edge
  t4_and_reload_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ5
    hit_t4_and_reload
      |=> (timer4 == {$past(reg_b), $past(acc)})
        && (timer4_low_reload_reg == {$past(reg_b), $past(acc)}) && timer4_load)
    else $error("timer 4 and reload register not loaded from B and accumulator");

  // the reload register has exactly one writer
  reload_quiet_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ5
    !hit_t4_and_reload |=> $stable(timer4_low_reload_reg))
    else $error("reload register changed without a load");

  // timer 4 moves, and its load pulse fires, only for the two timer 4 words
  t4_quiet_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
    !hit_timer4 |=> $stable(timer4) && !timer4_load)
    else $error("timer 4 changed without a timer 4 instruction");

  // loading timer 4 never writes B or the accumulator; only the load and reload word reads them
  t4_keeps_ab_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ1
    hit_timer4 |=> $stable(acc) && $stable(reg_b))
    else $error("timer 4 instruction disturbed B or the accumulator");

  // timer reads leave timer 4 and its reload register alone
  reads_keep_t4_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ4
    hit_read |=> $stable(timer4) && $stable(timer4_low_reload_reg) && !timer4_load)
    else $error("timer read disturbed timer 4");

  // the move from B touches nothing on the timer side
  move_keeps_t4_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
    hit_b_to_acc |=> $stable(timer4) && !timer4_load)
    else $error("move from B disturbed timer 4");

  // register B is written only by the two timer reads, and by reset
  b_source_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ3
    $changed(reg_b) |-> $past(hit_read) || $past(rst))
    else $error("register B changed without a timer read");

  // the accumulator is written only by the reads and the move from B
  acc_source_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ2
    $changed(acc) |-> $past(hit_read) || $past(hit_b_to_acc) || $past(rst))
    else $error("accumulator changed without a writing instruction");

  // words outside the group leave the working registers alone
  refused_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
    !hit_any |=> $stable(acc) && $stable(reg_b) && !instr_done)
    else $error("unknown word changed state or retired");

  // every group word retires in the very next cycle
  done_match_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
    hit_any |=> instr_done)
    else $error("group instruction did not retire in one cycle");

  // these words never ask the sequencer to skip
  never_skip_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
    !skip_next)
    else $error("skip requested by a transfer instruction");

  // one word decodes to exactly one operation, or to none
  op_onehot_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
    $onehot(dif.op))
    else $error("decoded operation is not one-hot");

  // the decoder and the raw word agree on whether a group word is present
  decode_none_a: assert property (@(posedge sys_clk) disable iff (rst) // RQ6
    (dif.op == TTX_OP_NONE) == !hit_any)
    else $error("decoder disagrees with the raw word");
endmodule

// ---- bench/tb_ttx_exec.sv ----
`timescale 1ns/10ps
`define CHK(got, want) begin compares++; if ((got) !== (want)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, got, want); end end
module tb_ttx_exec;
  import ttx_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [INSTR_W-1:0] instr_word = '0;
  logic [TMR_W-1:0] timer1 = 8'h00;
  logic [TMR_W-1:0] timer2 = 8'h00;
  logic [NIB_W-1:0] acc;
  logic [NIB_W-1:0] reg_b;
  logic [TMR_W-1:0] timer4;
  logic timer4_load;
  logic [TMR_W-1:0] timer4_low_reload_reg;
  logic instr_done;
  logic skip_next;
  int err_total = 0;
  int compares = 0;
  // ------------------------------------------------------------
  // clock and design
  // ------------------------------------------------------------
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  ttx_exec u_ttx_exec (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .timer1(timer1), .timer2(timer2), .acc(acc), .reg_b(reg_b),
    .timer4(timer4), .timer4_load(timer4_load),
    .timer4_low_reload_reg(timer4_low_reload_reg), .instr_done(instr_done),
    .skip_next(skip_next));
  // ------------------------------------------------------------
  // drivers: entered at a falling edge, leave at a falling edge
  // ------------------------------------------------------------
  // valid stays high so a following call runs back to back
  task automatic exec(input logic [INSTR_W-1:0] w);
    instr_valid = 1'b1;
    instr_word = w;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(skip_next, 1'b0)
  endtask
  // drops valid and checks the pulses lasted one cycle only
  task automatic idle();
    instr_valid = 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(instr_done, 1'b0)
    `CHK(timer4_load, 1'b0)
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reads();
    timer1 = 8'ha5;
    timer2 = 8'h3c;
    exec(OP_READ_T1);
    `CHK({reg_b, acc, instr_done}, {8'ha5, 1'b1})
    exec(OP_READ_T2);
    `CHK({reg_b, acc, instr_done}, {8'h3c, 1'b1})
    exec(OP_MOVE_B_TO_ACC);
    `CHK({reg_b, acc, instr_done}, {8'h33, 1'b1})
    idle();
  endtask
  task automatic t_timer4();
    timer1 = 8'h7e;
    exec(OP_READ_T1);
    exec(OP_LOAD_T4_AND_RELOAD);
    `CHK({timer4, timer4_low_reload_reg, timer4_load}, {16'h7e7e, 1'b1})
    idle();
    timer2 = 8'h5a;
    exec(OP_READ_T2);
    exec(OP_LOAD_T4_FROM_RELOAD);
    `CHK({timer4, timer4_load, instr_done}, {8'h7e, 2'b11})
    `CHK({reg_b, acc}, 8'h5a)
    idle();
  endtask
  // an unknown word leaves everything as it was
  task automatic t_refused();
    exec(10'h272);
    `CHK({reg_b, acc, timer4, instr_done, timer4_load}, {16'h5a7e, 2'b00})
    idle();
  endtask
  // each edge must use the values left by the edge before
  task automatic t_chain();
    timer1 = 8'h96;
    exec(OP_READ_T1);
    timer1 = 8'h00;
    exec(OP_LOAD_T4_AND_RELOAD);
    `CHK({timer4, timer4_low_reload_reg}, 16'h9696)
    exec(OP_MOVE_B_TO_ACC);
    `CHK({reg_b, acc, timer4}, 16'h9996)
    idle();
  endtask
  // load then copy on the very next word: the copy sees the fresh value
  task automatic t_pair();
    timer2 = 8'hc3;
    exec(OP_READ_T2);
    exec(OP_LOAD_T4_AND_RELOAD);
    exec(OP_LOAD_T4_FROM_RELOAD);
    `CHK({timer4, timer4_low_reload_reg, timer4_load}, {16'hc3c3, 1'b1})
    idle();
  endtask
  // reset in mid-run wins over a word presented at the same edge
  task automatic t_reset();
    rst = 1'b1;
    timer1 = 8'hff;
    exec(OP_READ_T1);
    `CHK({reg_b, acc, timer4, timer4_low_reload_reg}, {B_RST, ACC_RST, TMR4_RST, RELOAD4_RST})
    `CHK({instr_done, timer4_load}, 2'b00)
    rst = 1'b0;
    exec(OP_READ_T1);
    `CHK({reg_b, acc, instr_done}, {8'hff, 1'b1})
    idle();
  endtask
  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(negedge sys_clk);
    `CHK({acc, reg_b, timer4, timer4_low_reload_reg}, {ACC_RST, B_RST, TMR4_RST, RELOAD4_RST})
    `CHK({instr_done, timer4_load, skip_next}, 3'b000)
    rst = 1'b0;
    t_reads();
    t_timer4();
    t_refused();
    t_chain();
    t_pair();
    t_reset();
    wrap_up();
  end
endmodule
